// file: rtl/ppmsi_regs.sv
// per-port power management and msg_interrupt_capability_header register bank
// Operation
// [RULE1] power_mgmt_capability sits at 40h, id byte reads 01h
// [RULE2] pm next pointer is 5Ch upstream, 4Ch downstream
// [RULE3] pm revision field reads 011b
// [RULE4] pme clock, b2/b3 and bus power bits read zero
// [RULE5] device-specific-init bit defaults to zero
// [RULE6] aux current field defaults to 111b
// [RULE7] d1 and d2 support bits default to one
// [RULE8] pme support field defaults to 11111b
// [RULE9] read-only defaults can be reloaded by the side-band preload port
// [RULE10] power state at 44h bits 1:0, D0..D3hot, resets to D0
// [RULE11] D3 to D0 write gives hot reset, downstream reset untouched
// [RULE12] no-soft-reset bit resets one; clear means internal reset on exit
// [RULE13] pme enable bit 8 resets zero and gates pme messages
// [RULE14] pme status reads zero, data select writable, data scale zero
// [RULE15] power data byte resets 00h and is preloadable
// [RULE16] msg_interrupt_capability_header at 4Ch exists on downstream ports only
// [RULE17] msi id reads 05h, next pointer 64h
// [RULE18] msi enable selects message writes over intx; resets zero
// [RULE19] mm capable reads 000b, mm enable resets 000b, 64-bit bit one
// [RULE20] message address bits 31:2 at 50h, low bits reserved, reset zero
// [RULE21] upper address at 54h used only with 64-bit addressing
// [RULE22] downstream hot-plug uses intx when msi is disabled
// [RULE23] reserved bits read zero and ignore writes
`timescale 1ns/1ps
module ppmsi_regs (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic is_downstream,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  input wire logic pl_wr,
  input wire logic [2:0] pl_sel,
  input wire logic [7:0] pl_data,
  input wire logic hp_event,
  input wire logic hp_clear,
  input wire logic pme_event,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic [1:0] power_state,
  output logic pme_enable,
  output logic pme_msg,
  output logic hot_reset,
  output logic internal_reset,
  output logic downstream_reset_out_b,
  output logic msi_enable,
  output logic msi_req,
  output logic intx_assert,
  output logic [63:0] msi_addr
);
  // ------------------------------------------------------------
  // shared write path
  // ------------------------------------------------------------
  ppmsi_wr_if wb ();
  logic [7:0] waddr;
  logic dsi;
  logic [2:0] aux;
  logic [1:0] d1d2;
  logic [4:0] pme_sup;
  logic nsr;
  logic [7:0] pdata;
  logic msi_en;
  logic [2:0] mme;
  logic [31:0] addr_lo;
  logic [31:0] addr_hi;
  ppmsi_pkg::ppmsi_pstate_t ps_ff;
  ppmsi_pkg::ppmsi_pstate_t nxt_ps;
  logic pme_en_ff;
  logic [3:0] dsel_ff;
  logic hot_rst_ff;
  logic int_rst_ff;
  logic ps_wr;
  logic d3_exit;
  logic [31:0] nxt_rdata;
  logic [7:0] pm_next;

  // word-aligned byte address; byte lanes come from cfg_be
  assign waddr = {cfg_addr[7:2], 2'b00};
  assign wb.wr = cfg_wr;
  assign wb.addr = waddr;
  assign wb.wdata = cfg_wdata;
  assign wb.be = cfg_be;
  // internal reset of the function's writable state, one cycle late
  assign wb.soft_rst = int_rst_ff;

  ppmsi_preload u_preload (
    .mclk(mclk),
    .rst_b(rst_b),
    .pl_wr(pl_wr), // [RULE9]
    .pl_sel(pl_sel),
    .pl_data(pl_data),
    .dsi_ff(dsi),
    .aux_ff(aux),
    .d1d2_ff(d1d2),
    .pme_sup_ff(pme_sup),
    .nsr_ff(nsr),
    .pdata_ff(pdata)
  );

  ppmsi_msi u_msi (
    .mclk(mclk),
    .rst_b(rst_b),
    .is_downstream(is_downstream),
    .wb(wb),
    .msi_en_ff(msi_en),
    .mme_ff(mme),
    .addr_lo_ff(addr_lo),
    .addr_hi_ff(addr_hi)
  );

  // ------------------------------------------------------------
  // power state and d3 exit detection
  // ------------------------------------------------------------
  assign ps_wr = cfg_wr && waddr == ppmsi_pkg::PM_CSR_OFS && cfg_be[0];
  assign nxt_ps = ppmsi_pkg::ppmsi_pstate_t'(cfg_wdata[1:0]);
  assign d3_exit = ps_wr && ps_ff == ppmsi_pkg::PS_D3HOT && // [RULE11]
    nxt_ps == ppmsi_pkg::PS_D0;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ps_ff <= ppmsi_pkg::PS_D0; // [RULE10]
    else if (ps_wr)
      ps_ff <= nxt_ps; // [RULE10]
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hot_rst_ff <= 1'b0;
      int_rst_ff <= 1'b0;
    end
    else
    begin
      hot_rst_ff <= d3_exit; // [RULE11]
      int_rst_ff <= d3_exit && !nsr; // [RULE12]
    end
  end

  // never pulsed from here: a d3 exit resets only inside the port
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      downstream_reset_out_b <= 1'b1;
    else
      downstream_reset_out_b <= 1'b1; // [RULE11]
  end

  // ------------------------------------------------------------
  // pme enable and data select
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pme_en_ff <= 1'b0; // [RULE13]
      dsel_ff <= ppmsi_pkg::DSEL_RST; // [RULE14]
    end
    else if (int_rst_ff)
    begin
      pme_en_ff <= 1'b0;
      dsel_ff <= ppmsi_pkg::DSEL_RST;
    end
    else if (cfg_wr && waddr == ppmsi_pkg::PM_CSR_OFS && cfg_be[1])
    begin
      pme_en_ff <= cfg_wdata[ppmsi_pkg::PME_EN_BIT]; // [RULE13]
      dsel_ff <= cfg_wdata[ppmsi_pkg::DSEL_LSB +: 4]; // [RULE14]
    end
  end

  // ------------------------------------------------------------
  // event outputs: pme, msi and intx
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pme_msg <= 1'b0;
      msi_req <= 1'b0;
    end
    else
    begin
      pme_msg <= pme_event && pme_en_ff; // [RULE13]
      msi_req <= hp_event && is_downstream && msi_en; // [RULE18]
    end
  end

  // intx is a level until the handler clears it; a new event in the
  // clearing cycle keeps it asserted so the event is not lost
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      intx_assert <= 1'b0;
    else if (!is_downstream || msi_en)
      intx_assert <= 1'b0; // [RULE18]
    else if (hp_event)
      intx_assert <= 1'b1; // [RULE22]
    else if (hp_clear)
      intx_assert <= 1'b0;
  end

  // ------------------------------------------------------------
  // registered status copies
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      power_state <= 2'h0;
      pme_enable <= 1'b0;
      hot_reset <= 1'b0;
      internal_reset <= 1'b0;
      msi_enable <= 1'b0;
      msi_addr <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      power_state <= ps_ff;
      pme_enable <= pme_en_ff;
      hot_reset <= hot_rst_ff;
      internal_reset <= int_rst_ff;
      msi_enable <= msi_en && is_downstream;
      // upper half only counts with 64-bit addressing
      msi_addr <= {ppmsi_pkg::MSI_CAP64 ? addr_hi : 32'h0000_0000,
        addr_lo[31:ppmsi_pkg::ADDR_LSB], 2'b00}; // [RULE20] [RULE21]
    end
  end

  // ------------------------------------------------------------
  // read mux; unmapped and reserved space reads zero
  // ------------------------------------------------------------
  assign pm_next = is_downstream ? ppmsi_pkg::PM_NEXT_DN :
    ppmsi_pkg::PM_NEXT_UP; // [RULE2]

  always_comb
  begin
    nxt_rdata = 32'h0000_0000; // [RULE23]
    unique case (waddr)
      ppmsi_pkg::PM_CAP_OFS:
      begin
        nxt_rdata[7:0] = ppmsi_pkg::PM_CAP_ID; // [RULE1]
        nxt_rdata[15:8] = pm_next; // [RULE2]
        nxt_rdata[18:16] = ppmsi_pkg::PM_VERSION; // [RULE3]
        nxt_rdata[19] = 1'b0; // [RULE4]
        nxt_rdata[21] = dsi; // [RULE5]
        nxt_rdata[24:22] = aux; // [RULE6]
        nxt_rdata[26:25] = d1d2; // [RULE7]
        nxt_rdata[31:27] = pme_sup; // [RULE8]
      end
      ppmsi_pkg::PM_CSR_OFS:
      begin
        nxt_rdata[1:0] = ps_ff; // [RULE10]
        nxt_rdata[3] = nsr; // [RULE12]
        nxt_rdata[8] = pme_en_ff; // [RULE13]
        nxt_rdata[12:9] = dsel_ff; // [RULE14]
        nxt_rdata[15:13] = 3'h0; // [RULE14]
        nxt_rdata[23:16] = 8'h00; // [RULE4]
        nxt_rdata[31:24] = pdata; // [RULE15]
      end
      ppmsi_pkg::MSI_CAP_OFS:
      begin
        if (is_downstream) // [RULE16]
        begin
          nxt_rdata[7:0] = ppmsi_pkg::MSI_CAP_ID; // [RULE17]
          nxt_rdata[15:8] = ppmsi_pkg::MSI_NEXT; // [RULE17]
          nxt_rdata[16] = msi_en; // [RULE18]
          nxt_rdata[19:17] = ppmsi_pkg::MSI_MM_CAPABLE; // [RULE19]
          nxt_rdata[22:20] = mme; // [RULE19]
          nxt_rdata[23] = ppmsi_pkg::MSI_CAP64; // [RULE19]
        end
      end
      ppmsi_pkg::MSI_ADDR_OFS:
      begin
        if (is_downstream)
          nxt_rdata = {addr_lo[31:2], 2'b00}; // [RULE20]
      end
      ppmsi_pkg::MSI_UADDR_OFS:
      begin
        if (is_downstream)
          nxt_rdata = addr_hi; // [RULE21]
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= nxt_rdata;
    end
  end
endmodule

// file: rtl/ppmsi_pkg.sv
// constants and types of the per-port power management / msi registers
package ppmsi_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PM_CAP_OFS = 8'h40;
  localparam logic [7:0] PM_CSR_OFS = 8'h44;
  localparam logic [7:0] MSI_CAP_OFS = 8'h4c;
  localparam logic [7:0] MSI_ADDR_OFS = 8'h50;
  localparam logic [7:0] MSI_UADDR_OFS = 8'h54;
  // ------------------------------------------------------------
  // fixed header values
  // ------------------------------------------------------------
  localparam logic [7:0] PM_CAP_ID = 8'h01;
  localparam logic [7:0] PM_NEXT_UP = 8'h5c;
  localparam logic [7:0] PM_NEXT_DN = 8'h4c;
  localparam logic [2:0] PM_VERSION = 3'h3;
  localparam logic [7:0] MSI_CAP_ID = 8'h05;
  localparam logic [7:0] MSI_NEXT = 8'h64;
  localparam logic [2:0] MSI_MM_CAPABLE = 3'h0;
  localparam logic MSI_CAP64 = 1'b1;
  // ------------------------------------------------------------
  // reset values of preloadable read-only fields
  // ------------------------------------------------------------
  localparam logic DSI_RST = 1'b0;
  localparam logic [2:0] AUX_RST = 3'h7;
  localparam logic [1:0] D1D2_RST = 2'h3;
  localparam logic [4:0] PME_SUP_RST = 5'h1f;
  localparam logic NSR_RST = 1'b1;
  localparam logic [7:0] PDATA_RST = 8'h00;
  // ------------------------------------------------------------
  // preload field selects
  // ------------------------------------------------------------
  localparam logic [2:0] PL_DSI = 3'h0;
  localparam logic [2:0] PL_AUX = 3'h1;
  localparam logic [2:0] PL_D1D2 = 3'h2;
  localparam logic [2:0] PL_PME_SUP = 3'h3;
  localparam logic [2:0] PL_NSR = 3'h4;
  localparam logic [2:0] PL_PDATA = 3'h5;
  // ------------------------------------------------------------
  // writable field layout and resets
  // ------------------------------------------------------------
  localparam int PS_LSB = 0;
  localparam int PME_EN_BIT = 8;
  localparam int DSEL_LSB = 9;
  localparam int MSI_EN_BIT = 16;
  localparam int MME_LSB = 20;
  localparam int ADDR_LSB = 2;
  localparam logic [3:0] DSEL_RST = 4'h0;
  localparam logic [2:0] MME_RST = 3'h0;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    PS_D0 = 2'b00,
    PS_D1 = 2'b01,
    PS_D2 = 2'b10,
    PS_D3HOT = 2'b11
  } ppmsi_pstate_t;
endpackage

// file: rtl/ppmsi_wr_if.sv
// config write strobe shared by the register modules
`timescale 1ns/1ps
interface ppmsi_wr_if;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic soft_rst;
  modport src (output wr, addr, wdata, be, soft_rst);
  modport dst (input wr, addr, wdata, be, soft_rst);
endinterface

// file: rtl/ppmsi_preload.sv
// preloadable read-only capability defaults
`timescale 1ns/1ps
module ppmsi_preload (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pl_wr,
  input wire logic [2:0] pl_sel,
  input wire logic [7:0] pl_data,
  output logic dsi_ff,
  output logic [2:0] aux_ff,
  output logic [1:0] d1d2_ff,
  output logic [4:0] pme_sup_ff,
  output logic nsr_ff,
  output logic [7:0] pdata_ff
);
  // ------------------------------------------------------------
  // side-band loads; host config writes never reach these
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dsi_ff <= ppmsi_pkg::DSI_RST; // [RULE5]
      aux_ff <= ppmsi_pkg::AUX_RST; // [RULE6]
      d1d2_ff <= ppmsi_pkg::D1D2_RST; // [RULE7]
      pme_sup_ff <= ppmsi_pkg::PME_SUP_RST; // [RULE8]
      nsr_ff <= ppmsi_pkg::NSR_RST; // [RULE12]
      pdata_ff <= ppmsi_pkg::PDATA_RST; // [RULE15]
    end
    else if (pl_wr)
    begin
      unique case (pl_sel) // [RULE9]
        ppmsi_pkg::PL_DSI: dsi_ff <= pl_data[0];
        ppmsi_pkg::PL_AUX: aux_ff <= pl_data[2:0];
        ppmsi_pkg::PL_D1D2: d1d2_ff <= pl_data[1:0];
        ppmsi_pkg::PL_PME_SUP: pme_sup_ff <= pl_data[4:0];
        ppmsi_pkg::PL_NSR: nsr_ff <= pl_data[0];
        ppmsi_pkg::PL_PDATA: pdata_ff <= pl_data; // [RULE15]
        default: ;
      endcase
    end
  end
endmodule

// file: rtl/ppmsi_msi.sv
// message-signalled interrupt control and address registers
`timescale 1ns/1ps
module ppmsi_msi (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic is_downstream,
  ppmsi_wr_if.dst wb,
  output logic msi_en_ff,
  output logic [2:0] mme_ff,
  output logic [31:0] addr_lo_ff,
  output logic [31:0] addr_hi_ff
);
  logic hit_ctl;
  logic hit_lo;
  logic hit_hi;
  localparam logic MSI_CAP64_ON = ppmsi_pkg::MSI_CAP64;
  // upstream port has no such capability: writes ignored
  assign hit_ctl = wb.wr && is_downstream && // [RULE16]
    wb.addr == ppmsi_pkg::MSI_CAP_OFS;
  assign hit_lo = wb.wr && is_downstream &&
    wb.addr == ppmsi_pkg::MSI_ADDR_OFS;
  assign hit_hi = wb.wr && is_downstream &&
    wb.addr == ppmsi_pkg::MSI_UADDR_OFS;
  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      msi_en_ff <= 1'b0; // [RULE18]
      mme_ff <= ppmsi_pkg::MME_RST; // [RULE19]
    end
    else if (wb.soft_rst)
    begin
      msi_en_ff <= 1'b0;
      mme_ff <= ppmsi_pkg::MME_RST;
    end
    else if (hit_ctl && wb.be[2])
    begin
      msi_en_ff <= wb.wdata[ppmsi_pkg::MSI_EN_BIT]; // [RULE18]
      mme_ff <= wb.wdata[ppmsi_pkg::MME_LSB +: 3]; // [RULE19]
    end
  end
  // ------------------------------------------------------------
  // address, per byte lane; low two bits stay zero
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_lo_ff <= ppmsi_pkg::ADDR_RST; // [RULE20]
      addr_hi_ff <= ppmsi_pkg::ADDR_RST;
    end
    else if (wb.soft_rst)
    begin
      addr_lo_ff <= ppmsi_pkg::ADDR_RST;
      addr_hi_ff <= ppmsi_pkg::ADDR_RST;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (hit_lo && wb.be[i])
          addr_lo_ff[i*8 +: 8] <= wb.wdata[i*8 +: 8];
        if (hit_hi && wb.be[i] && MSI_CAP64_ON)
          addr_hi_ff[i*8 +: 8] <= wb.wdata[i*8 +: 8]; // [RULE21]
      end
      addr_lo_ff[1:0] <= 2'h0; // [RULE23]
    end
  end
endmodule

// file: verification/ppmsi_regs_monitor.sv
// assertion checker bound to the pm / msi register bank
`timescale 1ns/1ps
module ppmsi_regs_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic is_downstream,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  input wire logic hp_event,
  input wire logic pme_event,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [1:0] power_state,
  input wire logic pme_enable,
  input wire logic pme_msg,
  input wire logic hot_reset,
  input wire logic internal_reset,
  input wire logic downstream_reset_out_b,
  input wire logic msi_enable,
  input wire logic msi_req,
  input wire logic intx_assert,
  input wire logic [63:0] msi_addr
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  chk_pm_header: assert property (
    cfg_rd && cfg_addr[7:2] == 6'h10 |=>
    {cfg_rdata[20:16], cfg_rdata[7:0]} == 13'h0301)
    else $error("pm header id or revision wrong");
  chk_csr_reserved: assert property (
    cfg_rvalid && $past(cfg_addr) inside {[8'h44:8'h47]} |->
    (cfg_rdata & 32'h00ff_e0f4) == 32'h0)
    else $error("fixed power control bits not zero");
  // power_state lags the field a cycle: a write just before makes it stale
  chk_hot_delay: assert property (
    cfg_wr && !$past(cfg_wr) && cfg_addr[7:2] == 6'h11 && cfg_be[0] &&
    cfg_wdata[1:0] == 2'b00 && power_state == 2'b11 |=> ##1 hot_reset)
    else $error("no hot reset two cycles after d3 exit");
  chk_nsr_gate: assert property (
    internal_reset |-> hot_reset)
    else $error("internal reset outside d3 exit");
  // pme_enable is the copy of the enable that gated the event
  chk_pme_gate: assert property (
    pme_msg |-> $past(pme_event) && pme_enable)
    else $error("pme message without enabled event");
  chk_msi_req: assert property (
    msi_req |-> $past(hp_event) && msi_enable)
    else $error("message request without enable");
  chk_intx_set: assert property (
    hp_event && is_downstream |=> intx_assert || msi_enable)
    else $error("legacy interrupt not raised");
  chk_intx_off: assert property (
    msi_enable |-> !intx_assert)
    else $error("legacy interrupt while messages on");
  chk_up_no_msi: assert property (
    !is_downstream |-> !msi_enable && !msi_req)
    else $error("message interrupt on upstream port");
  chk_addr_align: assert property (
    msi_addr[1:0] == 2'b00)
    else $error("message address not dword aligned");
  chk_dsrst_idle: assert property (
    downstream_reset_out_b)
    else $error("downstream reset driven");
  cov_hot: cover property (hot_reset && internal_reset);
  cov_msi: cover property (msi_req);
  cov_intx: cover property ($rose(intx_assert));
endmodule

bind ppmsi_regs ppmsi_regs_monitor u_mon (
  .mclk, .rst_b, .is_downstream, .cfg_wr, .cfg_rd, .cfg_addr,
  .cfg_wdata, .cfg_be, .hp_event, .pme_event, .cfg_rdata, .cfg_rvalid,
  .power_state, .pme_enable, .pme_msg, .hot_reset, .internal_reset,
  .downstream_reset_out_b, .msi_enable, .msi_req, .intx_assert,
  .msi_addr
);

// file: verification/ppmsi_host.sv
// host configuration software model issuing config accesses
`timescale 1ns/1ps
module ppmsi_host (
  input wire logic mclk,
  input wire logic cfg_rvalid,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  output logic [3:0] cfg_be
);
  // ------
  // access tasks
  // ------
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = '0;
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    // stale data flipped so a late sample cannot pass by luck
    cfg_wdata <= ~d;
  endtask
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    #1;
    d = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
  endtask
endmodule

// file: verification/test_port_pm_msg_interrupt_capability_header_regs.sv
// self-checking bench of the pm / msi register bank
`timescale 1ns/1ps
module test_port_pm_msg_interrupt_capability_header_regs;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] be;
    logic [31:0] wd;
    logic [31:0] ex;
  } ppmsi_row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic is_downstream = 1'b1;
  logic pl_wr = 1'b0;
  logic [2:0] pl_sel = 3'h0;
  logic [7:0] pl_data = 8'h0;
  logic [2:0] ev = 3'h0;
  logic cfg_wr, cfg_rd, cfg_rvalid, pme_enable, pme_msg, hot_reset;
  logic internal_reset, downstream_reset_out_b, msi_enable, msi_req;
  logic intx_assert;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [3:0] cfg_be;
  logic [1:0] power_state;
  logic [63:0] msi_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  ppmsi_row_t rows [10] = '{
    '{8'h40, 4'h0, 32'h0, 32'hffc3_4c01},
    '{8'h44, 4'h0, 32'h0, 32'h0000_0008},
    '{8'h4c, 4'h0, 32'h0, 32'h0080_6405},
    '{8'h50, 4'h0, 32'h0, 32'h0},
    '{8'h48, 4'hf, 32'hffff_ffff, 32'h0},
    '{8'h40, 4'hf, 32'h0, 32'hffc3_4c01},
    '{8'h44, 4'hf, 32'hffff_ffff, 32'h0000_1f0b},
    '{8'h4c, 4'hf, 32'hffff_ffff, 32'h00f1_6405},
    '{8'h50, 4'hf, 32'hffff_ffff, 32'hffff_fffc},
    '{8'h54, 4'hf, 32'hffff_ffff, 32'hffff_ffff}};
  ppmsi_regs uut (
    .mclk, .rst_b, .is_downstream, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_be, .pl_wr, .pl_sel, .pl_data,
    .hp_event(ev[0]), .hp_clear(ev[1]), .pme_event(ev[2]),
    .cfg_rdata, .cfg_rvalid, .power_state, .pme_enable, .pme_msg,
    .hot_reset, .internal_reset, .downstream_reset_out_b,
    .msi_enable, .msi_req, .intx_assert, .msi_addr
  );
  ppmsi_host host (
    .mclk, .cfg_rvalid, .cfg_rdata, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_be
  );
  // ------
  // clock, timeout and helpers
  // ------
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] d;
    host.cfg_read(a, d);
    check(d, ex);
  endtask
  task automatic pl(input logic [2:0] s, input logic [7:0] d);
    @(posedge mclk);
    pl_wr <= 1'b1;
    pl_sel <= s;
    pl_data <= d;
    @(posedge mclk);
    pl_wr <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 3'h0;
    #1;
  endtask
  task automatic do_reset(input logic ds);
    @(posedge mclk);
    rst_b <= 1'b0;
    is_downstream <= ds;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
  endtask
  // ------
  // main sequence
  // ------
  initial
  begin
    do_reset(1'b1);
    foreach (rows[i])
    begin
      host.cfg_write(rows[i].a, rows[i].be, rows[i].wd);
      rd(rows[i].a, rows[i].ex);
    end
    check(msi_addr, 64'hffff_ffff_ffff_fffc);
    check(pme_enable, 1'h1);
    pulse(3'h1);
    check({msi_req, intx_assert}, 2'h2);
    pulse(3'h4);
    check(pme_msg, 1'h1);
    host.cfg_write(8'h44, 4'h1, 32'h0);
    @(posedge mclk);
    #1;
    check({hot_reset, internal_reset}, 2'h2);
    check(downstream_reset_out_b, 1'h1);
    rd(8'h44, 32'h0000_1f08);
    pl(3'h4, 8'h00);
    host.cfg_write(8'h44, 4'h1, 32'h3);
    rd(8'h44, 32'h0000_1f03);
    check(power_state, 2'h3);
    host.cfg_write(8'h44, 4'h1, 32'h0);
    @(posedge mclk);
    #1;
    check({hot_reset, internal_reset}, 2'h3);
    rd(8'h44, 32'h0);
    check(pme_enable, 1'h0);
    rd(8'h4c, 32'h0080_6405);
    rd(8'h54, 32'h0);
    pulse(3'h4);
    check(pme_msg, 1'h0);
    pulse(3'h1);
    check({msi_req, intx_assert}, 2'h1);
    pulse(3'h2);
    check(intx_assert, 1'h0);
    pulse(3'h1);
    host.cfg_write(8'h4c, 4'h4, 32'h0001_0000);
    @(posedge mclk);
    #1;
    check({msi_enable, intx_assert}, 2'h2);
    pl(3'h0, 8'h01);
    pl(3'h1, 8'h02);
    pl(3'h2, 8'h01);
    pl(3'h3, 8'h15);
    pl(3'h5, 8'ha5);
    rd(8'h40, 32'haaa3_4c01);
    rd(8'h44, 32'ha500_0000);
    do_reset(1'b0);
    rd(8'h40, 32'hffc3_5c01);
    host.cfg_write(8'h4c, 4'hf, 32'hffff_ffff);
    rd(8'h4c, 32'h0);
    pulse(3'h1);
    check({msi_enable, msi_req}, 2'h0);
    finish_test;
  end
endmodule
